// *** tb/poc_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Register access master
// ----------------------------------------
module poc_host (
  input  wire logic              clk_sys,
  input  wire poc_pkg::poc_rsp_s rsp,
  output var  poc_pkg::poc_req_s req
);
  poc_pkg::poc_rsp_s got;
  initial req = '0;
  // One access: one-cycle request, release, take answer
  task automatic xfer(input logic w, input logic [2:0] c,
                      input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, w, c, a, d};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
    got = rsp;
  endtask
endmodule // poc_host
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic              clk_sys, rst, stp, ccw, hw, zb, rs, pa;
  logic [31:0]       lp, pos;
  logic [12:0]       ang;
  logic [15:0]       amp, pst, aref, a5, vc, cc;
  logic              ve, vb, cen, rerr;
  logic [1:0]        lim;
  poc_pkg::poc_req_s req;
  poc_pkg::poc_rsp_s rsp;
  int                num_errors = 0;
  int                compares = 0;
  poc_host i_host (.clk_sys(clk_sys), .rsp(rsp), .req(req));
  poc_top #(.DEBOUNCE_CYCLES(20)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .reg_req(req),
    .reg_rsp_q(rsp), .max_position_count(32'h000FFFFF),
    .step_valid(stp), .step_ccw(ccw), .hw_reset_pin(hw),
    .zero_button_pin(zb), .restore_start(rs), .last_position(lp),
    .angle_now(ang), .optical_amp(amp), .pair_step(pst),
    .pair_active(pa), .adc_ref(aref), .adc_5v(a5),
    .adc_12v(16'h0C00), .adc_24v(16'h1800), .position_q(pos),
    .volt_en_q(ve), .volt_bipolar_q(vb), .volt_code_q(vc),
    .cur_en_q(cen), .cur_code_q(cc), .limit_q(lim),
    .restore_err_q(rerr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [2:0] c,
                    input logic [31:0] d);
    i_host.xfer(1'b1, c, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [2:0] c);
    i_host.xfer(1'b0, c, a, 32'h0);
  endtask
  task automatic load(input logic [31:0] v);
    wr(poc_pkg::A_PRESET, 3'h2, v);
    zb <= 1'b1;
    cyc(5);
    zb <= 1'b0;
    cyc(5);
    chk(pos, v);
  endtask
  task automatic step(input logic d, input logic [31:0] e);
    stp <= 1'b1;
    ccw <= d;
    cyc(1);
    stp <= 1'b0;
    cyc(2);
    chk(pos, e);
  endtask
  task automatic pulse();
    rs <= 1'b1;
    cyc(1);
    rs <= 1'b0;
    cyc(3);
  endtask
  task automatic t_regs();
    rd(poc_pkg::A_AMP, 3'h1);
    chk(i_host.got.rdata, {16'h0, amp});
    chk({i_host.got.ack, i_host.got.err}, 2'h2);
    rd(poc_pkg::A_STATUS, 3'h5);
    chk(i_host.got.rdata[15:0], amp);
    pa <= 1'b1;
    rd(poc_pkg::A_PAIR, 3'h1);
    chk(i_host.got.rdata, {16'h0, pst});
    pa <= 1'b0;
    rd(poc_pkg::A_PAIR, 3'h1);
    chk(i_host.got.rdata, 32'h0);
    wr(poc_pkg::A_AMP, 3'h1, 32'h5);
    chk(i_host.got.code, poc_pkg::ERR_REG);
    wr(poc_pkg::A_RSV_LO, 3'h1, 32'h1);
    chk(i_host.got.code, poc_pkg::ERR_REG);
    rd(poc_pkg::A_VMODE, 3'h2);
    chk(i_host.got.code, poc_pkg::ERR_CNT);
    wr(poc_pkg::A_VMODE, 3'h1, 32'h4);
    chk(i_host.got.code, poc_pkg::ERR_VAL);
    wr(poc_pkg::A_RANGE, 3'h1, 32'h1000);
    chk(i_host.got.code, poc_pkg::ERR_VAL);
    wr(poc_pkg::A_RANGE, 3'h1, 32'h0FFF);
    chk({i_host.got.ack, i_host.got.err}, 2'h2);
    rd(poc_pkg::A_RANGE, 3'h1);
    chk(i_host.got.rdata, 32'h0FFF);
    a5 <= 16'h1111;
    aref <= 16'h2222;
    rd(poc_pkg::A_S5, 3'h1);
    chk(i_host.got.rdata, 32'h0500);
    rd(poc_pkg::A_S12, 3'h1);
    chk(i_host.got.rdata, 32'h0C00);
    rd(poc_pkg::A_REF, 3'h1);
    chk(i_host.got.rdata, 32'h2222);
  endtask
  task automatic t_out();
    for (int m = 0; m < 4; m++) begin
      wr(poc_pkg::A_VMODE, 3'h1, 32'(m));
      cyc(2);
      chk({ve, vb}, {m != 0, m == 3});
    end
    for (int m = 0; m < 3; m++) begin
      wr(poc_pkg::A_CMODE, 3'h1, 32'(m));
      cyc(2);
      chk(cen, m != 0);
    end
    wr(poc_pkg::A_VSCALE, 3'h2, 32'd100);
    wr(poc_pkg::A_CSCALE, 3'h2, 32'd100);
    load(32'd100);
    chk(vc, 16'hFFFF);
    chk(cc, 16'hFFFF);
    load(32'd50);
    chk(vc, 16'h7FFF);
    chk(cc, 16'h7FFF);
  endtask
  task automatic t_cnt();
    wr(poc_pkg::A_SENSE, 3'h1, 32'h0);
    step(1'b0, 32'd51);
    step(1'b1, 32'd50);
    wr(poc_pkg::A_SENSE, 3'h1, 32'h1);
    step(1'b1, 32'd51);
    wr(poc_pkg::A_PRESET, 3'h2, 32'd7);
    hw <= 1'b1;
    cyc(6);
    chk(pos, 32'd7);
    step(1'b1, 32'd8);
    hw <= 1'b0;
    wr(poc_pkg::A_RMODE, 3'h1, 32'h1);
    hw <= 1'b1;
    cyc(10);
    hw <= 1'b0;
    cyc(30);
    chk(pos, 32'd8);
    hw <= 1'b1;
    cyc(30);
    chk(pos, 32'd7);
    hw <= 1'b0;
  endtask
  task automatic t_lim();
    wr(poc_pkg::A_L1LO, 3'h2, 32'd50);
    wr(poc_pkg::A_L1HI, 3'h2, 32'd150);
    wr(poc_pkg::A_L2LO, 3'h2, 32'd200);
    wr(poc_pkg::A_L2HI, 3'h2, 32'd300);
    load(32'd150);
    chk(lim, 2'b01);
    load(32'd151);
    chk(lim, 2'b00);
    load(32'd200);
    chk(lim, 2'b10);
  endtask
  task automatic t_rest();
    wr(poc_pkg::A_RANGE, 3'h1, 32'd10);
    lp <= {19'h3, 13'd100};
    ang <= 13'd110;
    pulse();
    chk(pos, 32'd200);
    wr(poc_pkg::A_PUMODE, 3'h1, 32'h1);
    pulse();
    chk(pos, {19'h3, 13'd110});
    chk(rerr, 1'b0);
    ang <= 13'd111;
    pulse();
    chk(rerr, 1'b1);
    chk(pos, {19'h3, 13'd110});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, stp, ccw, hw, zb, rs, pa} = 7'b1000000;
    {lp, ang, amp, pst, aref, a5} = {32'h0, 13'h0, 16'h01F4,
                                     16'h0007, 16'h09C4, 16'h0500};
    cyc(20);
    rst <= 1'b0;
    t_regs();
    t_out();
    t_cnt();
    t_lim();
    t_rest();
    tally_and_finish();
  end
  initial begin
    cyc(20000);
    num_errors++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire

// *** verilog/poc_pkg.sv ***
`default_nettype none
package poc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned DEBOUNCE_MS  = 60;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] A_STATUS = 16'h0000;
  localparam logic [15:0] A_AMP    = 16'h010A;
  localparam logic [15:0] A_PAIR   = 16'h010B;
  localparam logic [15:0] A_RSV_LO = 16'h010C;
  localparam logic [15:0] A_RSV_HI = 16'h010E;
  localparam logic [15:0] A_VMODE  = 16'h0200;
  localparam logic [15:0] A_VSCALE = 16'h0201;
  localparam logic [15:0] A_CMODE  = 16'h0204;
  localparam logic [15:0] A_CSCALE = 16'h0205;
  localparam logic [15:0] A_RMODE  = 16'h0208;
  localparam logic [15:0] A_PRESET = 16'h0209;
  localparam logic [15:0] A_SENSE  = 16'h020B;
  localparam logic [15:0] A_PUMODE = 16'h020C;
  localparam logic [15:0] A_L1LO   = 16'h0230;
  localparam logic [15:0] A_L1HI   = 16'h0232;
  localparam logic [15:0] A_L2LO   = 16'h0234;
  localparam logic [15:0] A_L2HI   = 16'h0236;
  localparam logic [15:0] A_RANGE  = 16'h0237;
  localparam logic [15:0] A_REF    = 16'h0300;
  localparam logic [15:0] A_S5     = 16'h0301;
  localparam logic [15:0] A_S12    = 16'h0302;
  localparam logic [15:0] A_S24    = 16'h0303;
  localparam logic [15:0] A_UNU_LO = 16'h0304;
  localparam logic [15:0] A_UNU_HI = 16'h0306;
  // ----------------------------------------
  // Counts, limits, codes, fields
  // ----------------------------------------
  localparam logic [2:0]  CNT_NONE  = 3'h0;
  localparam logic [2:0]  CNT_ONE   = 3'h1;
  localparam logic [2:0]  CNT_TWO   = 3'h2;
  localparam logic [2:0]  CNT_COMB  = 3'h5;
  localparam logic [15:0] VMODE_MAX = 16'h0003;
  localparam logic [15:0] CMODE_MAX = 16'h0002;
  localparam logic [15:0] BIN_MAX   = 16'h0001;
  localparam logic [15:0] RANGE_MAX = 16'h0FFF;
  localparam logic [15:0] VM_OFF    = 16'h0000;
  localparam logic [15:0] VM_ST     = 16'h0001;
  localparam logic [15:0] VM_BI     = 16'h0003;
  localparam logic [15:0] CM_OFF    = 16'h0000;
  localparam logic [15:0] CM_ST     = 16'h0001;
  localparam logic [15:0] RM_DEB    = 16'h0001;
  localparam logic [15:0] PU_REST   = 16'h0001;
  localparam logic [15:0] ERR_REG   = 16'h0402;
  localparam logic [15:0] ERR_CNT   = 16'h0403;
  localparam logic [15:0] ERR_VAL   = 16'h0405;
  localparam logic [15:0] DAC_FULL  = 16'hFFFF;
  localparam int unsigned TURN_BITS = 13;
  localparam logic [15:0] RST_W16   = 16'h0000;
  localparam logic [31:0] RST_W32   = 32'h00000000;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [2:0]  count;
    logic [15:0] addr;
    logic [31:0] wdata;
  } poc_req_s;
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] code;
    logic [31:0] rdata;
  } poc_rsp_s;
  typedef enum logic [1:0] {D_IDLE, D_WAIT, D_HELD} poc_deb_e;
endpackage
`default_nettype wire

// *** verilog/poc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module poc_top #(
  parameter int unsigned DEBOUNCE_CYCLES = poc_pkg::DEBOUNCE_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire poc_pkg::poc_req_s reg_req,
  output var  poc_pkg::poc_rsp_s reg_rsp_q,
  input  wire logic [31:0]      max_position_count,
  input  wire logic             step_valid,
  input  wire logic             step_ccw,
  input  wire logic             hw_reset_pin,
  input  wire logic             zero_button_pin,
  input  wire logic             restore_start,
  input  wire logic [31:0]      last_position,
  input  wire logic [12:0]      angle_now,
  input  wire logic [15:0]      optical_amp,
  input  wire logic [15:0]      pair_step,
  input  wire logic             pair_active,
  input  wire logic [15:0]      adc_ref,
  input  wire logic [15:0]      adc_5v,
  input  wire logic [15:0]      adc_12v,
  input  wire logic [15:0]      adc_24v,
  output logic [31:0]           position_q,
  output logic                  volt_en_q,
  output logic                  volt_bipolar_q,
  output logic [15:0]           volt_code_q,
  output logic                  cur_en_q,
  output logic [15:0]           cur_code_q,
  output logic [1:0]            limit_q,
  output logic                  restore_err_q
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [15:0] ratio(input logic [31:0] p,
                                        input logic [31:0] s);
    logic [47:0] num;
    num = ({p, 16'h0000} - {16'h0000, p}) / {16'h0000, s};
    if ((s == 32'h0) || (p >= s)) ratio = poc_pkg::DAC_FULL;
    else ratio = num[15:0];
  endfunction

  function automatic logic [2:0] exp_count(input logic [15:0] a,
                                           input logic [2:0] c);
    exp_count = poc_pkg::CNT_NONE;
    if ((a == poc_pkg::A_STATUS) && (c == poc_pkg::CNT_COMB))
      exp_count = poc_pkg::CNT_COMB;
    else if ((a == poc_pkg::A_VSCALE) || (a == poc_pkg::A_CSCALE) ||
             (a == poc_pkg::A_PRESET) || (a == poc_pkg::A_L1LO) ||
             (a == poc_pkg::A_L1HI) || (a == poc_pkg::A_L2LO) ||
             (a == poc_pkg::A_L2HI))
      exp_count = poc_pkg::CNT_TWO;
    else if ((a == poc_pkg::A_AMP) || (a == poc_pkg::A_PAIR) ||
             ((a >= poc_pkg::A_RSV_LO) && (a <= poc_pkg::A_RSV_HI)) ||
             (a == poc_pkg::A_VMODE) || (a == poc_pkg::A_CMODE) ||
             (a == poc_pkg::A_RMODE) || (a == poc_pkg::A_SENSE) ||
             (a == poc_pkg::A_PUMODE) || (a == poc_pkg::A_RANGE) ||
             ((a >= poc_pkg::A_REF) && (a <= poc_pkg::A_UNU_HI)))
      exp_count = poc_pkg::CNT_ONE;
  endfunction

  function automatic logic [12:0] circ_dist(input logic [12:0] a,
                                            input logic [12:0] b);
    logic [12:0] d;
    d = a - b;
    circ_dist = d[12] ? (13'h0000 - d) : d;
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [15:0] vmode_q, cmode_q, rmode_q, sense_q, pumode_q, range_q;
  logic [31:0] vscale_q, cscale_q, preset_q;
  logic [31:0] l1lo_q, l1hi_q, l2lo_q, l2hi_q;
  logic [15:0] s5_q, s12_q, s24_q;
  logic        sampled_q;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire [15:0] ra    = reg_req.addr;
  wire [31:0] wd    = reg_req.wdata;
  wire [2:0]  ecnt  = exp_count(ra, reg_req.count);
  wire        is_ro = (ecnt == poc_pkg::CNT_COMB) ||
                      (ra == poc_pkg::A_AMP) || (ra == poc_pkg::A_PAIR) ||
                      ((ra >= poc_pkg::A_RSV_LO) &&
                       (ra <= poc_pkg::A_RSV_HI)) ||
                      (ra >= poc_pkg::A_REF);
  wire        w_wide = (ecnt == poc_pkg::CNT_TWO);
  wire        ok_val = w_wide ? (wd <= max_position_count) :
                       (ra == poc_pkg::A_VMODE)  ? wd[15:0] <= poc_pkg::VMODE_MAX :
                       (ra == poc_pkg::A_CMODE)  ? wd[15:0] <= poc_pkg::CMODE_MAX :
                       (ra == poc_pkg::A_RANGE)  ? wd[15:0] <= poc_pkg::RANGE_MAX :
                       (wd[15:0] <= poc_pkg::BIN_MAX);
  wire        bad_reg = (ecnt == poc_pkg::CNT_NONE) ||
                        (reg_req.wr && is_ro);
  wire        bad_cnt = !bad_reg && (reg_req.count != ecnt);
  wire        bad_val = !bad_reg && !bad_cnt && reg_req.wr &&
                        (!ok_val || (wd[31:16] != 16'h0000 && !w_wide));
  wire        do_wr   = reg_req.valid && reg_req.wr &&
                        !bad_reg && !bad_cnt && !bad_val;
  wire [15:0] err_code = bad_reg ? poc_pkg::ERR_REG :
                         bad_cnt ? poc_pkg::ERR_CNT : poc_pkg::ERR_VAL;
  wire        any_err = bad_reg || bad_cnt || bad_val;
  wire [15:0] pair_rd = pair_active ? pair_step : 16'h0000;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (ra)
      poc_pkg::A_STATUS: rd_mux = {16'h0000, optical_amp};
      poc_pkg::A_AMP:    rd_mux = {16'h0000, optical_amp};
      poc_pkg::A_PAIR:   rd_mux = {16'h0000, pair_rd};
      poc_pkg::A_VMODE:  rd_mux = {16'h0000, vmode_q};
      poc_pkg::A_VSCALE: rd_mux = vscale_q;
      poc_pkg::A_CMODE:  rd_mux = {16'h0000, cmode_q};
      poc_pkg::A_CSCALE: rd_mux = cscale_q;
      poc_pkg::A_RMODE:  rd_mux = {16'h0000, rmode_q};
      poc_pkg::A_PRESET: rd_mux = preset_q;
      poc_pkg::A_SENSE:  rd_mux = {16'h0000, sense_q};
      poc_pkg::A_PUMODE: rd_mux = {16'h0000, pumode_q};
      poc_pkg::A_L1LO:   rd_mux = l1lo_q;
      poc_pkg::A_L1HI:   rd_mux = l1hi_q;
      poc_pkg::A_L2LO:   rd_mux = l2lo_q;
      poc_pkg::A_L2HI:   rd_mux = l2hi_q;
      poc_pkg::A_RANGE:  rd_mux = {16'h0000, range_q};
      poc_pkg::A_REF:    rd_mux = {16'h0000, adc_ref};
      poc_pkg::A_S5:     rd_mux = {16'h0000, s5_q};
      poc_pkg::A_S12:    rd_mux = {16'h0000, s12_q};
      poc_pkg::A_S24:    rd_mux = {16'h0000, s24_q};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Register file and response
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rsp_q <= '0;
    end else if (ce) begin
      reg_rsp_q.ack   <= reg_req.valid;
      reg_rsp_q.err   <= reg_req.valid && any_err;
      reg_rsp_q.code  <= (reg_req.valid && any_err) ? err_code : 16'h0000;
      reg_rsp_q.rdata <= (reg_req.valid && !any_err && !reg_req.wr) ?
                         rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vmode_q <= poc_pkg::RST_W16;
      cmode_q <= poc_pkg::RST_W16;
      rmode_q <= poc_pkg::RST_W16;
      sense_q <= poc_pkg::RST_W16;
      pumode_q <= poc_pkg::RST_W16;
      range_q <= poc_pkg::RST_W16;
      vscale_q <= poc_pkg::RST_W32;
      cscale_q <= poc_pkg::RST_W32;
      preset_q <= poc_pkg::RST_W32;
      l1lo_q <= poc_pkg::RST_W32;
      l1hi_q <= poc_pkg::RST_W32;
      l2lo_q <= poc_pkg::RST_W32;
      l2hi_q <= poc_pkg::RST_W32;
    end else if (ce && do_wr) begin
      case (ra)
        poc_pkg::A_VMODE:  vmode_q <= wd[15:0];
        poc_pkg::A_CMODE:  cmode_q <= wd[15:0];
        poc_pkg::A_RMODE:  rmode_q <= wd[15:0];
        poc_pkg::A_SENSE:  sense_q <= wd[15:0];
        poc_pkg::A_PUMODE: pumode_q <= wd[15:0];
        poc_pkg::A_RANGE:  range_q <= wd[15:0];
        poc_pkg::A_VSCALE: vscale_q <= wd;
        poc_pkg::A_CSCALE: cscale_q <= wd;
        poc_pkg::A_PRESET: preset_q <= wd;
        poc_pkg::A_L1LO:   l1lo_q <= wd;
        poc_pkg::A_L1HI:   l1hi_q <= wd;
        poc_pkg::A_L2LO:   l2lo_q <= wd;
        poc_pkg::A_L2HI:   l2hi_q <= wd;
        default: ;
      endcase
    end
  end

  // Supplies latched once, first enabled cycle after reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sampled_q <= 1'b0;
      s5_q <= poc_pkg::RST_W16;
      s12_q <= poc_pkg::RST_W16;
      s24_q <= poc_pkg::RST_W16;
    end else if (ce && !sampled_q) begin
      sampled_q <= 1'b1;
      s5_q <= adc_5v;
      s12_q <= adc_12v;
      s24_q <= adc_24v;
    end
  end

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  logic [1:0] hw_sync_q, zb_sync_q;
  logic       hw_prev_q, zb_prev_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hw_sync_q <= 2'h0;
      zb_sync_q <= 2'h0;
      hw_prev_q <= 1'b0;
      zb_prev_q <= 1'b0;
    end else if (ce) begin
      hw_sync_q <= {hw_sync_q[0], hw_reset_pin};
      zb_sync_q <= {zb_sync_q[0], zero_button_pin};
      hw_prev_q <= hw_sync_q[1];
      zb_prev_q <= zb_sync_q[1];
    end
  end
  wire hw_lvl  = hw_sync_q[1];
  wire hw_rise = hw_lvl && !hw_prev_q;
  wire zb_rise = zb_sync_q[1] && !zb_prev_q;

  // ----------------------------------------
  // Debounce of counter reset input
  // ----------------------------------------
  poc_pkg::poc_deb_e deb_q;
  logic [19:0]       deb_cnt_q;
  wire [19:0] deb_last = 20'(DEBOUNCE_CYCLES - 1);
  wire deb_fire = (deb_q == poc_pkg::D_WAIT) && hw_lvl &&
                  (deb_cnt_q == deb_last);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      deb_q <= poc_pkg::D_IDLE;
      deb_cnt_q <= 20'h00000;
    end else if (ce) begin
      case (deb_q)
        poc_pkg::D_IDLE: begin
          deb_cnt_q <= 20'h00000;
          if (hw_rise) deb_q <= poc_pkg::D_WAIT;
        end
        poc_pkg::D_WAIT: begin
          if (!hw_lvl) deb_q <= poc_pkg::D_IDLE;
          else if (deb_fire) deb_q <= poc_pkg::D_HELD;
          else deb_cnt_q <= deb_cnt_q + 20'h00001;
        end
        poc_pkg::D_HELD: if (!hw_lvl) deb_q <= poc_pkg::D_IDLE;
        default: deb_q <= poc_pkg::D_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Position counter
  // ----------------------------------------
  wire hw_load = (rmode_q == poc_pkg::RM_DEB) ? deb_fire : hw_rise;
  wire do_preset = hw_load || zb_rise;
  wire try_rest = restore_start && (pumode_q == poc_pkg::PU_REST);
  wire rest_ok = {3'h0, circ_dist(last_position[12:0], angle_now)} <=
                 range_q;
  wire count_up = (step_ccw == sense_q[0]);
  wire [31:0] pos_inc = (position_q >= max_position_count) ? 32'h0 :
                        position_q + 32'h1;
  wire [31:0] pos_dec = (position_q == 32'h0) ? max_position_count :
                        position_q - 32'h1;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      position_q <= poc_pkg::RST_W32;
      restore_err_q <= 1'b0;
    end else if (ce) begin
      if (try_rest) begin
        restore_err_q <= !rest_ok;
        if (rest_ok) position_q <= {last_position[31:13], angle_now};
      end else if (do_preset) begin
        position_q <= preset_q;
      end else if (step_valid) begin
        position_q <= count_up ? pos_inc : pos_dec;
      end
    end
  end

  // ----------------------------------------
  // Analog output codes and limit switches
  // ----------------------------------------
  wire [31:0] pos_st = {19'h00000, position_q[poc_pkg::TURN_BITS-1:0]};
  wire [31:0] v_pos  = (vmode_q == poc_pkg::VM_ST) ? pos_st : position_q;
  wire [31:0] c_pos  = (cmode_q == poc_pkg::CM_ST) ? pos_st : position_q;
  wire l1_in = (position_q >= l1lo_q) && (position_q <= l1hi_q);
  wire l2_in = (position_q >= l2lo_q) && (position_q <= l2hi_q);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      volt_en_q <= 1'b0;
      volt_bipolar_q <= 1'b0;
      volt_code_q <= 16'h0000;
      cur_en_q <= 1'b0;
      cur_code_q <= 16'h0000;
      limit_q <= 2'h0;
    end else if (ce) begin
      volt_en_q <= (vmode_q != poc_pkg::VM_OFF);
      volt_bipolar_q <= (vmode_q == poc_pkg::VM_BI);
      volt_code_q <= ratio(v_pos, vscale_q);
      cur_en_q <= (cmode_q != poc_pkg::CM_OFF);
      cur_code_q <= ratio(c_pos, cscale_q);
      limit_q <= {l2_in, l1_in};
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_amp_read;
    @(posedge clk_sys) disable iff (rst)
    (ce && reg_req.valid && !reg_req.wr && ra == poc_pkg::A_AMP &&
     reg_req.count == poc_pkg::CNT_ONE)
    |=> reg_rsp_q.rdata == {16'h0000, $past(optical_amp)};
  endproperty
  a_amp_read: assert property (p_amp_read)
    else $error("amplitude read wrong");
  property p_comb_read;
    @(posedge clk_sys) disable iff (rst)
    (ce && reg_req.valid && !reg_req.wr && ra == poc_pkg::A_STATUS &&
     reg_req.count == poc_pkg::CNT_COMB)
    |=> !reg_rsp_q.err && reg_rsp_q.rdata[15:0] == $past(optical_amp);
  endproperty
  a_comb_read: assert property (p_comb_read)
    else $error("combined read lacks amplitude");
  property p_pair_idle;
    @(posedge clk_sys) disable iff (rst)
    (ce && reg_req.valid && !reg_req.wr && ra == poc_pkg::A_PAIR &&
     !pair_active) |=> reg_rsp_q.rdata == 32'h0;
  endproperty
  a_pair_idle: assert property (p_pair_idle)
    else $error("progress shown outside pairing");
  property p_vmode;
    @(posedge clk_sys) disable iff (rst)
    ce |=> volt_en_q == ($past(vmode_q) != poc_pkg::VM_OFF) &&
           volt_bipolar_q == ($past(vmode_q) == poc_pkg::VM_BI);
  endproperty
  a_vmode: assert property (p_vmode)
    else $error("voltage mode decode wrong");
  property p_vfull;
    @(posedge clk_sys) disable iff (rst)
    (ce && v_pos == vscale_q) |=> volt_code_q == poc_pkg::DAC_FULL;
  endproperty
  a_vfull: assert property (p_vfull)
    else $error("no full voltage at scale");
  property p_cur;
    @(posedge clk_sys) disable iff (rst)
    (ce && c_pos == cscale_q && cmode_q != poc_pkg::CM_OFF)
    |=> cur_en_q && cur_code_q == poc_pkg::DAC_FULL;
  endproperty
  a_cur: assert property (p_cur)
    else $error("current not at 20mA at scale");
  property p_edge;
    @(posedge clk_sys) disable iff (rst)
    (ce && hw_rise && rmode_q != poc_pkg::RM_DEB && !try_rest)
    |=> position_q == $past(preset_q);
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge reset did not preset");
  property p_deb;
    @(posedge clk_sys) disable iff (rst)
    deb_fire |-> hw_lvl && deb_cnt_q == deb_last && $past(hw_lvl);
  endproperty
  a_deb: assert property (p_deb)
    else $error("debounce fired early");
  property p_limit;
    @(posedge clk_sys) disable iff (rst)
    ce |=> limit_q[0] == ($past(position_q) >= $past(l1lo_q) &&
                          $past(position_q) <= $past(l1hi_q));
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit output wrong");
  property p_supply;
    @(posedge clk_sys) disable iff (rst)
    sampled_q |=> $stable(s5_q) && $stable(s12_q) && $stable(s24_q);
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply reading refreshed");
  property p_wrongval;
    @(posedge clk_sys) disable iff (rst)
    (ce && reg_req.valid && bad_val)
    |=> reg_rsp_q.err && reg_rsp_q.code == poc_pkg::ERR_VAL;
  endproperty
  a_wrongval: assert property (p_wrongval)
    else $error("wrong value not reported");
  property p_restore;
    @(posedge clk_sys) disable iff (rst)
    (ce && try_rest) |=> restore_err_q == !$past(rest_ok);
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore check wrong");
  c_deb: cover property (@(posedge clk_sys) disable iff (rst) deb_fire);
  c_rest: cover property (@(posedge clk_sys) disable iff (rst)
    ce && try_rest && rest_ok);
  c_bad: cover property (@(posedge clk_sys) disable iff (rst)
    ce && reg_req.valid && bad_val);
endmodule // poc_top
`default_nettype wire
